//--- dma_context_list_control.v
// Descriptor-list context control engine with its register file
// Summary of operation
// - Zero-count branch: fetch branch pointer once more
// - Still zero ends list, else continue
// - Clear list-changed before each fetch or refetch
// - List-changed ignored while go is clear
// - Only engine sets busy, on go or changed
// - Busy clears: end, stop, fatal, reset
// - Async transmit contexts drop busy on bus reset
// - Busy falling with go clear raises completion
// - Fatal error sets fatal, clears busy, keeps go
// - Fatal raises global error, suppresses completion
// - Fatal clears only by go clear or reset
// - Fatal cause recorded as completion event code
// - Bad count at go start is fatal
// - Pointer readback is the engine's pointer, whatever the flags
// - Count readback free except after write
// - Control examined at every scheduling slot
// - Isochronous stop waits for packet end
// - Pointer holds 28 address bits and count
`timescale 1ns/10ps
`include "ctx_consts.vh"
module dma_context_list_control (
  input  wire        core_clk,         // 100 MHz clock
  input  wire        sys_rst,          // Hardware reset, synchronous high
  input  wire [3:0]  address,          // Avalon word address
  input  wire        read,             // Avalon read
  input  wire        write,            // Avalon write
  input  wire [31:0] writedata,        // Avalon write data
  output wire        waitrequest,      // Avalon wait
  output wire [31:0] readdata,         // Avalon read data
  input  wire        sched_slot,       // Scheduling slot pulse from the datapath
  input  wire        bus_reset_pin,    // Serial bus reset level from outside
  input  wire        pkt_in_flight,    // Datapath is mid-packet
  output reg         fetch_req_r,      // Descriptor fetch request level
  output reg  [27:0] desc_block_pointer, // Address of block being fetched
  input  wire        fetch_ack,        // Fetch done pulse
  input  wire        fetch_err,        // Fetch failed, with fetch_ack
  input  wire [31:0] fetch_branch,     // Branch pointer word of fetched block
  input  wire        desc_done,        // Block fully executed pulse
  input  wire        desc_irq_req,     // Completed block asks for interrupt
  input  wire        proc_err,         // Fatal processing error pulse
  input  wire [4:0]  proc_err_code,    // Event code of that error
  output reg         run_out_r,        // Datapath may process packets
  output reg         irq_event_reg,    // Completion event pulse
  output reg         fatal_irq_event   // Global unrecoverable event pulse
);
  // Engine states
  localparam ST_IDLE  = 3'd0;
  localparam ST_FETCH = 3'd1;
  localparam ST_RUN   = 3'd2;
  localparam ST_REFET = 3'd3;
  localparam ST_STOP  = 3'd4;

  reg [2:0]  state_r;          // Engine state
  reg        go_r;             // Software go flag
  reg        changed_r;        // List-changed flag
  reg        busy_r;           // Busy flag, engine owned
  reg        fatal_r;          // Fatal-halt flag
  reg [4:0]  code_r;           // Completion event code
  reg [31:0] list_pointer_reg; // Pointer: address[31:4], count[3:0]
  reg [31:0] next_ptr_r;       // Branch awaiting the next fetch
  reg [1:0]  kind_r;           // Context kind
  reg [31:0] evt_cnt_r;        // Count of completion events, readable
  reg        busy_d_r;         // Busy one cycle ago
  reg        start_r;          // Fresh go waits for its first slot
  wire       bus_rst_s;        // Synchronised bus reset
  wire       chg_set;          // Software sets list-changed this cycle
  wire       wr_stb;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  reg [31:0] rd_value;

  // A software append in the same cycle as an engine clear must survive,
  // so the engine clears of list-changed before a fetch or refetch are gated by this strobe
  assign chg_set = wr_stb && (wr_addr == `ADDR_CTRL_SET) && wr_data[`BIT_CHANGED];

  // Count field check for the context kind
  function count_ok;
    input [3:0] z;
    input [1:0] kind;
    begin
      count_ok = (kind == `KIND_ASYNC_RX) ? (z == 4'h1) : (z != 4'h0);
    end
  endfunction

  sync3 u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (bus_reset_pin),
    .dout_r   (bus_rst_s)
  );

  avmm_slave u_bus (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .rd_value    (rd_value),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .wr_stb_r    (wr_stb),
    .wr_addr_r   (wr_addr),
    .wr_data_r   (wr_data)
  );

  // Read mux; pointer reads back the engine's view
  always @* begin
    if (address == `ADDR_CTRL || address == `ADDR_CTRL_SET || address == `ADDR_CTRL_CLR) begin
      rd_value = 32'h00000000;
      rd_value[`BIT_GO]      = go_r;
      rd_value[`BIT_CHANGED] = changed_r;
      rd_value[`BIT_FATAL]   = fatal_r;
      rd_value[`BIT_BUSY]    = busy_r;
      rd_value[`CODE_MSB:`CODE_LSB] = code_r;
    end else if (address == `ADDR_LIST_PTR) begin
      rd_value = list_pointer_reg;
    end else if (address == `ADDR_CFG) begin
      rd_value = {30'h00000000, kind_r};
    end else if (address == `ADDR_EVENTS) begin
      rd_value = evt_cnt_r;
    end else begin
      rd_value = `UNMAPPED_DATA;
    end
  end

  // Main control process: flags, pointer, fetch sequencing
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_r          <= ST_IDLE;
      go_r             <= 1'b0;
      changed_r        <= 1'b0;
      busy_r           <= 1'b0;
      fatal_r          <= 1'b0;
      code_r           <= 5'h00;
      list_pointer_reg <= 32'h00000000;
      next_ptr_r       <= 32'h00000000;
      kind_r           <= `KIND_ASYNC_TX;
      fetch_req_r      <= 1'b0;
      desc_block_pointer <= 28'h0000000;
      run_out_r        <= 1'b0;
      busy_d_r         <= 1'b0;
      start_r          <= 1'b0;
      evt_cnt_r        <= 32'h00000000;
      irq_event_reg    <= 1'b0;
      fatal_irq_event  <= 1'b0;
    end else begin
      irq_event_reg   <= 1'b0;
      fatal_irq_event <= 1'b0;
      busy_d_r        <= busy_r;
      // Software writes; set and clear registers avoid read-modify-write races
      if (wr_stb) begin
        if (wr_addr == `ADDR_CTRL_SET) begin
          if (wr_data[`BIT_GO]) begin
            go_r <= 1'b1;
            // Only a clear-to-set change of go starts a list; a repeat is ignored
            if (!go_r) begin
              start_r <= 1'b1;
            end
          end
          if (wr_data[`BIT_CHANGED]) begin
            changed_r <= 1'b1;
          end
        end else if (wr_addr == `ADDR_CTRL_CLR) begin
          if (wr_data[`BIT_GO]) begin
            // Clearing go ends a fatal halt and forgets its cause
            go_r    <= 1'b0;
            fatal_r <= 1'b0;
            code_r  <= 5'h00;
            start_r <= 1'b0;
          end
          if (wr_data[`BIT_CHANGED]) begin
            changed_r <= 1'b0;
          end
        end else if (wr_addr == `ADDR_LIST_PTR) begin
          // Not guarded: software must only write while idle
          list_pointer_reg <= wr_data;
        end else if (wr_addr == `ADDR_CFG) begin
          kind_r <= wr_data[`CFG_KIND_MSB:`CFG_KIND_LSB];
        end
      end
      // Completion event when busy falls with go already clear, unless fatal
      if (busy_d_r && !busy_r && !go_r && !fatal_r) begin
        irq_event_reg <= 1'b1;
        evt_cnt_r     <= evt_cnt_r + 32'h00000001;
      end else if (desc_done && desc_irq_req && !fatal_r) begin
        irq_event_reg <= 1'b1;
        evt_cnt_r     <= evt_cnt_r + 32'h00000001;
      end
      // Fatal halt holds busy clear
      if (fatal_r) begin
        busy_r      <= 1'b0;
        fetch_req_r <= 1'b0;
        run_out_r   <= 1'b0;
        state_r     <= ST_IDLE;
      end else if (bus_rst_s && kind_r == `KIND_ASYNC_TX && busy_r && !fetch_req_r) begin
        // Level, not edge: an outstanding fetch is let finish first, then busy drops
        busy_r      <= 1'b0;
        fetch_req_r <= 1'b0;
        run_out_r   <= 1'b0;
        state_r     <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            // Slot check: a fresh go starts at the pointer, a wake rereads the tail.
            // Without the fresh-go mark an ended list would restart at every slot.
            if (sched_slot && go_r && !busy_r && start_r) begin
              start_r <= 1'b0;
              if (!count_ok(list_pointer_reg[`PTR_Z_MSB:0], kind_r)) begin
                fatal_r         <= 1'b1;
                code_r          <= `EVT_UNKNOWN;
                fatal_irq_event <= 1'b1;
              end else begin
                busy_r      <= 1'b1;
                if (!chg_set) begin
                  changed_r <= 1'b0;
                end
                fetch_req_r <= 1'b1;
                desc_block_pointer <= list_pointer_reg[31:`PTR_ADDR_LSB];
                state_r     <= ST_FETCH;
              end
            end else if (sched_slot && go_r && changed_r && !busy_r) begin
              // Wake after the list ended: reread the tail's branch pointer
              busy_r      <= 1'b1;
              if (!chg_set) begin
                changed_r <= 1'b0;
              end
              fetch_req_r <= 1'b1;
              desc_block_pointer <= list_pointer_reg[31:`PTR_ADDR_LSB];
              state_r     <= ST_REFET;
            end else if (!go_r) begin
              // Go clear: list-changed is disregarded
              changed_r <= 1'b0;
            end
          end
          ST_FETCH, ST_REFET: begin
            if (fetch_ack) begin
              fetch_req_r <= 1'b0;
              if (fetch_err) begin
                fatal_r         <= 1'b1;
                code_r          <= `EVT_DESC_READ;
                fatal_irq_event <= 1'b1;
              end else if (state_r == ST_REFET) begin
                if (fetch_branch[`PTR_Z_MSB:0] == 4'h0) begin
                  busy_r  <= 1'b0;
                  state_r <= ST_IDLE;
                end else begin
                  list_pointer_reg <= fetch_branch;
                  next_ptr_r <= fetch_branch;
                  run_out_r  <= go_r;
                  state_r    <= ST_RUN;
                end
              end else begin
                next_ptr_r <= fetch_branch;
                run_out_r  <= go_r;
                state_r    <= ST_RUN;
              end
            end
          end
          ST_RUN: begin
            if (proc_err) begin
              fatal_r         <= 1'b1;
              code_r          <= proc_err_code;
              fatal_irq_event <= 1'b1;
            end else if (!go_r) begin
              state_r <= ST_STOP;
            end else if (desc_done) begin
              run_out_r <= 1'b0;
              // An append landing in this cycle keeps the flag set
              if (!chg_set) begin
                changed_r <= 1'b0;
              end
              fetch_req_r <= 1'b1;
              if (next_ptr_r[`PTR_Z_MSB:0] == 4'h0) begin
                // Re-read the tail's pointer in case software appended
                desc_block_pointer <= list_pointer_reg[31:`PTR_ADDR_LSB];
                state_r <= ST_REFET;
              end else begin
                list_pointer_reg   <= next_ptr_r;
                desc_block_pointer <= next_ptr_r[31:`PTR_ADDR_LSB];
                state_r <= ST_FETCH;
              end
            end
          end
          ST_STOP: begin
            // Isochronous contexts finish the packet in flight first
            if (!pkt_in_flight || kind_r == `KIND_ASYNC_TX || kind_r == `KIND_ASYNC_RX) begin
              run_out_r <= 1'b0;
              busy_r    <= 1'b0;
              state_r   <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

//--- ctx_consts.vh
// Register offsets, field positions and codes of the context list control block
`ifndef CTX_CONSTS_VH
`define CTX_CONSTS_VH
// Register word addresses (byte address / 4 on the slave port)
`define ADDR_CTRL_SET    4'h0
`define ADDR_CTRL_CLR    4'h1
`define ADDR_CTRL        4'h2
`define ADDR_LIST_PTR    4'h3
`define ADDR_CFG         4'h4
`define ADDR_EVENTS      4'h5
`define ADDR_FETCH_ADDR  4'h6
`define ADDR_FETCH_DATA  4'h7
`define ADDR_DONE        4'h8
// Control register bit positions
`define BIT_GO           15
`define BIT_CHANGED      12
`define BIT_BUSY         10
`define BIT_FATAL        11
`define CODE_LSB         0
`define CODE_MSB         4
// Config register fields
`define CFG_KIND_LSB     0
`define CFG_KIND_MSB     1
`define KIND_ASYNC_TX    2'h0
`define KIND_ASYNC_RX    2'h1
`define KIND_ISO_TX      2'h2
`define KIND_ISO_RX      2'h3
// Event codes recorded on a fatal halt
`define EVT_DESC_READ    5'h16
`define EVT_UNKNOWN      5'h1e
// Pointer field layout
`define PTR_ADDR_LSB     4
`define PTR_Z_MSB        3
// Read answer to an unmapped address
`define UNMAPPED_DATA    32'h00000000
`endif

//--- sync3.v
// Three-stage synchroniser with agreement filter for an external level
`timescale 1ns/10ps
module sync3 (
  input  wire core_clk,  // Block clock
  input  wire sys_rst,   // Synchronous reset
  input  wire din,       // Asynchronous input
  output reg  dout_r     // Filtered level
);
  reg s1_r;  // First stage, read only by s2_r
  reg s2_r;  // Second stage
  reg s3_r;  // Third stage

  // Change is taken only once stages two and three agree
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout_r <= s3_r;
      end
    end
  end
endmodule

//--- avmm_slave.v
// Avalon-MM slave front end: registers one request, answers one cycle later
`timescale 1ns/10ps
module avmm_slave (
  input  wire        core_clk,      // Block clock
  input  wire        sys_rst,       // Synchronous reset
  input  wire [3:0]  address,       // Word address
  input  wire        read,          // Read request
  input  wire        write,         // Write request
  input  wire [31:0] writedata,     // Write data
  input  wire [31:0] rd_value,      // Register value for the held address
  output reg         waitrequest,   // Stall until answer ready
  output reg  [31:0] readdata,      // Read data
  output reg         wr_stb_r,      // One-cycle write strobe
  output reg  [3:0]  wr_addr_r,     // Write address
  output reg  [31:0] wr_data_r      // Write data
);
  reg done_r;  // Set in the answer cycle so the next edge raises waitrequest again

  // Every request is taken on the second edge; waitrequest falls in between
  always @(posedge core_clk) begin
    if (sys_rst) begin
      done_r      <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      wr_stb_r    <= 1'b0;
      wr_addr_r   <= 4'h0;
      wr_data_r   <= 32'h00000000;
    end else begin
      wr_stb_r <= 1'b0;
      if ((read || write) && !done_r) begin
        done_r      <= 1'b1;
        waitrequest <= 1'b0;
        readdata    <= rd_value;
        wr_stb_r    <= write;
        wr_addr_r   <= address;
        wr_data_r   <= writedata;
      end else begin
        // Release cycle: waitrequest back high before the next request
        done_r      <= 1'b0;
        waitrequest <= 1'b1;
      end
    end
  end
endmodule

//--- ctx_chk.sv
// Port checker of the descriptor-list context engine
`timescale 1ns/10ps
module ctx_chk (
  input wire        core_clk,           // Clock
  input wire        sys_rst,            // Reset
  input wire        read,               // Bus read
  input wire        write,              // Bus write
  input wire        waitrequest,        // Bus stall
  input wire        fetch_req_r,        // Fetch level
  input wire [27:0] desc_block_pointer, // Fetch block
  input wire        fetch_ack,          // Fetch answer
  input wire        fetch_err,          // Fetch failed
  input wire        proc_err,           // Packet fault
  input wire        run_out_r,          // Packets allowed
  input wire        irq_event_reg,      // Completion event
  input wire        fatal_irq_event     // Fatal event
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Fetch answer steps, plain and failed
  sequence s_ack_ok; fetch_req_r && fetch_ack && !fetch_err; endsequence
  sequence s_ack_bad; fetch_req_r && fetch_ack && fetch_err; endsequence
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_bus_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer too long");
  a_fetch_hold: assert property (fetch_req_r && !fetch_ack |=> fetch_req_r && $stable(desc_block_pointer))
    else $error("fetch dropped or moved");
  a_fetch_ends: assert property (s_ack_ok |=> !fetch_req_r)
    else $error("fetch held after answer");
  a_bad_fetch: assert property (s_ack_bad |-> ##[1:3] fatal_irq_event)
    else $error("failed fetch not fatal");
  a_bad_proc: assert property (run_out_r && proc_err |-> ##[1:3] fatal_irq_event)
    else $error("packet fault not fatal");
  a_fatal_quiet: assert property (fatal_irq_event |-> (!irq_event_reg && !fetch_req_r)[*5])
    else $error("activity after fatal halt");
  a_fatal_stop: assert property (fatal_irq_event |-> ##2 !run_out_r)
    else $error("packets still allowed");
  a_irq_pulse: assert property (irq_event_reg |=> !irq_event_reg)
    else $error("completion event too long");
endmodule
bind dma_context_list_control ctx_chk chk_u (.core_clk, .sys_rst, .read, .write, .waitrequest, .fetch_req_r,
  .desc_block_pointer, .fetch_ack, .fetch_err, .proc_err, .run_out_r, .irq_event_reg, .fatal_irq_event);

//--- fetch_model.sv
// Partner model: descriptor memory and packet datapath
`timescale 1ns/10ps
module fetch_model (
  input  wire        core_clk,      // Clock
  input  wire        sys_rst,       // Reset
  input  wire        fetch_req_r,   // Fetch request
  input  wire        run_out_r,     // Packets allowed
  input  wire [31:0] branch_word,   // Branch to return
  input  wire [3:0]  slow,          // Answer delay
  input  wire [1:0]  mode,          // 1 fetch fault, 2 packet fault, 3 irq ask
  output reg         fetch_ack,     // Answer pulse
  output reg         fetch_err,     // Fault flag
  output reg  [31:0] fetch_branch,  // Branch word
  output reg         desc_done,     // Block done
  output reg         desc_irq_req,  // Irq ask
  output reg         proc_err,      // Packet fault
  output reg  [4:0]  proc_err_code, // Fault code
  output reg         pkt_in_flight, // Mid-packet
  output integer     n_fetch        // Answers given
);
  reg [1:0] phase_r; // 0 idle, 1 answer wait, 2 packet
  reg [3:0] cnt_r;   // Phase counter
  // Lines outside an answer keep changing so stale data is never trusted
  always @(posedge core_clk) begin
    fetch_ack <= 1'b0;
    desc_done <= 1'b0;
    proc_err <= 1'b0;
    fetch_branch <= ~fetch_branch;
    fetch_err <= ~fetch_err;
    if (sys_rst) begin
      phase_r <= 2'h0;
      pkt_in_flight <= 1'b0;
      fetch_branch <= 32'h0;
      fetch_err <= 1'b0;
      n_fetch <= 0;
    end else if (phase_r == 2'h0) begin
      phase_r <= {1'b0, fetch_req_r};
      cnt_r <= slow;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      pkt_in_flight <= run_out_r && phase_r[1];
    end else if (phase_r == 2'h1) begin
      fetch_ack <= 1'b1;
      fetch_err <= (mode == 2'h1);
      fetch_branch <= branch_word;
      n_fetch <= n_fetch + 1;
      phase_r <= 2'h2;
      cnt_r <= 4'h4;
    end else begin
      // Packet finished: report done or a fault
      phase_r <= 2'h0;
      pkt_in_flight <= 1'b0;
      desc_done <= run_out_r && (mode != 2'h2);
      desc_irq_req <= (mode == 2'h3);
      proc_err <= run_out_r && (mode == 2'h2);
      proc_err_code <= branch_word[8:4];
    end
  end
endmodule

//--- dma_context_list_control_bench.sv
// Self-checking bench of the descriptor-list context engine
`timescale 1ns/10ps
`include "ctx_consts.vh"
module dma_context_list_control_bench;
  reg         core_clk, sys_rst, read, write, sched_slot, bus_reset_pin; // Driven inputs
  reg  [3:0]  address, slow;          // Bus address, model delay
  reg  [1:0]  mode;                   // Model fault select
  reg  [31:0] writedata, branch_word, rd, a; // Bus data, branch, read value, block
  wire        waitrequest, fetch_req_r, run_out_r, irq_event_reg, fatal_irq_event;
  wire        fetch_ack, fetch_err, desc_done, desc_irq_req, proc_err, pkt_in_flight;
  wire [31:0] readdata, fetch_branch;
  wire [27:0] desc_block_pointer;
  wire [4:0]  proc_err_code;
  integer     n_fetch, n_mismatch, checks, seed, cycles, n_irq, n_fatal, i0, f0, j0, k;
  localparam [31:0] MSK = 32'h8c00, MSKC = 32'h8c1f, AM = 32'hfffffff0; // Flags, flags+code, address
  dma_context_list_control dut_u (.core_clk, .sys_rst, .address, .read, .write, .writedata, .waitrequest,
    .readdata, .sched_slot, .bus_reset_pin, .pkt_in_flight, .fetch_req_r, .desc_block_pointer, .fetch_ack,
    .fetch_err, .fetch_branch, .desc_done, .desc_irq_req, .proc_err, .proc_err_code, .run_out_r,
    .irq_event_reg, .fatal_irq_event);
  fetch_model mdl_u (.core_clk, .sys_rst, .fetch_req_r, .run_out_r, .branch_word, .slow, .mode, .fetch_ack,
    .fetch_err, .fetch_branch, .desc_done, .desc_irq_req, .proc_err, .proc_err_code, .pkt_in_flight, .n_fetch);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Slot every 8 cycles, event tallies, hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    sched_slot <= (cycles[2:0] == 3'h0);
    if (!sys_rst) n_irq <= n_irq + irq_event_reg;
    if (!sys_rst) n_fatal <= n_fatal + fatal_irq_event;
    if (cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  function [31:0] cw(input g, input f, input b, input [4:0] c);
    cw = (g << `BIT_GO) | (f << `BIT_FATAL) | (b << `BIT_BUSY) | c;
  endfunction
  // One bus cycle; held until waitrequest is seen low
  task bus(input w, input [3:0] ad, input [31:0] d);
    begin
      read <= !w;
      write <= w;
      address <= ad;
      writedata <= d;
      @(posedge core_clk);
      while (waitrequest !== 1'b0) @(posedge core_clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Poll control until the masked flags match, bounded
  task ctl(input [31:0] m, input [31:0] e, input [95:0] nm);
    integer t;
    begin
      t = 0;
      bus(0, `ADDR_CTRL, 0);
      while ((rd & m) !== e && t < 200) begin
        bus(0, `ADDR_CTRL, 0);
        t = t + 1;
      end
      chk(nm, e, rd & m);
    end
  endtask
  task wait_fetch(input integer n);
    begin
      repeat (2000) if (n_fetch < n) @(posedge core_clk);
      if (n_fetch < n) chk("fetch wait", n, n_fetch);
    end
  endtask
  task start(input [1:0] kd, input [3:0] z);
    begin
      a = $random(seed);
      slow <= $random(seed);
      bus(1, `ADDR_CFG, {30'h0, kd});
      bus(1, `ADDR_LIST_PTR, {a[31:4], z});
      {i0, f0, j0} = {n_irq, n_fetch, n_fatal};
      bus(1, `ADDR_CTRL_SET, cw(1, 0, 0, 5'h0));
    end
  endtask
  task stop;
    begin
      bus(1, `ADDR_CTRL_CLR, cw(1, 0, 0, 5'h0));
      ctl(MSKC, 32'h0, "stopped");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    {sys_rst, read, write, sched_slot, bus_reset_pin} = 5'h10;
    {address, slow, mode, writedata, branch_word} = 74'h0;
    {n_mismatch, checks, cycles, n_irq, n_fatal} = 160'h0;
    seed = 14;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    bus(0, `ADDR_CTRL, 0);
    chk("reset ctrl", 32'h0, rd & MSKC);
    bus(0, 4'hf, 0);
    chk("unmapped", `UNMAPPED_DATA, rd);
    // Invalid count at start, every context kind
    for (k = 0; k < 4; k = k + 1) begin
      start(k[1:0], (k == 1) ? 4'h2 : 4'h0);
      ctl(MSKC, cw(1, 1, 0, `EVT_UNKNOWN), "bad count");
      chk("no fetch", f0, n_fetch);
      chk("fatal evt", j0 + 1, n_fatal);
      stop;
    end
    $display("test bad count done");
    branch_word <= $random(seed) & AM;
    start(`KIND_ISO_TX, 4'h1);
    wait_fetch(f0 + 2);
    ctl(MSK, cw(1, 0, 0, 5'h0), "list end");
    repeat (30) @(posedge core_clk);
    chk("refetch", f0 + 2, n_fetch);
    chk("no irq", i0, n_irq);
    bus(0, `ADDR_LIST_PTR, 0);
    chk("end ptr", a & AM, rd & AM);
    chk("fetch blk", a[31:4], desc_block_pointer);
    $display("test list end done");
    a = $random(seed);
    branch_word <= {a[31:4], 4'h1};
    bus(1, `ADDR_CTRL_SET, 32'h1 << `BIT_CHANGED);
    wait_fetch(f0 + 4);
    branch_word <= {a[31:4], 4'h0};
    ctl(MSK, cw(1, 0, 0, 5'h0), "append end");
    bus(0, `ADDR_LIST_PTR, 0);
    chk("append ptr", a & AM, rd & AM);
    branch_word <= {a[31:4], 4'h1};
    bus(1, `ADDR_CTRL_SET, 32'h1 << `BIT_CHANGED);
    wait_fetch(n_fetch + 3);
    i0 = n_irq;
    stop;
    chk("stop irq", i0 + 1, n_irq);
    f0 = n_fetch;
    bus(1, `ADDR_CTRL_SET, 32'h1 << `BIT_CHANGED);
    repeat (40) @(posedge core_clk);
    ctl(MSK, 32'h0, "wake idle");
    chk("idle fetch", f0, n_fetch);
    $display("test append stop done");
    mode <= 2'h1;
    start(`KIND_ISO_RX, 4'h3);
    ctl(MSKC, cw(1, 1, 0, `EVT_DESC_READ), "fetch err");
    chk("fatal evt", j0 + 1, n_fatal);
    chk("no irq", i0, n_irq);
    bus(0, `ADDR_LIST_PTR, 0);
    chk("fault ptr", a & AM, rd & AM);
    mode <= 2'h2;
    stop;
    start(`KIND_ASYNC_RX, 4'h1);
    ctl(MSKC, cw(1, 1, 0, branch_word[8:4]), "proc err");
    mode <= 2'h0;
    stop;
    $display("test fatal done");
    mode <= 2'h3;
    start(`KIND_ASYNC_TX, 4'h1);
    wait_fetch(f0 + 2);
    chk("blk irq", 1, n_irq > i0);
    bus_reset_pin <= 1'b1;
    ctl(MSK, cw(1, 0, 0, 5'h0), "bus reset");
    bus_reset_pin <= 1'b0;
    stop;
    $display("test bus reset done");
    finish_test;
  end
endmodule
